// [hdl/vector_regfile.sv]
// Purpose: Eight-entry 128-bit packed single-precision vector register file.
// Assumes: Decode and execution units drive requests synchronous to SYS_CLK.
// Notes: Reads answer one cycle after the request; writes land at the next edge.
`timescale 1ns/100ps

// Functional notes
// RULE1: eight 128-bit registers, index selected
// RULE2: operands only, never memory addresses
// RULE3: four lanes, lane 0 lowest
// RULE4: memory transfers in 64/128-bit blocks
// RULE5: lane operations parallel and independent
// RULE6: bits 0..127, little-endian bytes
// RULE7: separate from legacy register stack
// RULE8: full mode moves all 128 bits
// RULE9: 32-bit mode touches lane 0 only
// RULE10: sign, 8-bit biased exponent, 23-bit fraction
// RULE11: implied bit zero for zero/denormal
// RULE12: infinity, signalling and quiet NaN
// RULE13: masked invalid gives default quiet NaN
// RULE14: 32-bit lane, 24-bit precision
// RULE15: scalar store covers four bytes
// RULE16: usable in every execution mode
module vector_regfile (
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input vreg_pkg::wr_req_t WR_REQ,
   input wire logic INVALID_MASKED,
   input vreg_pkg::rd_req_t RD_REQ,
   output vreg_pkg::rd_rsp_t RD_RSP
);
   import vreg_pkg::*;

   // The storage proper, one 128-bit word per register.
   // RULE1: eight indexed registers
   logic [VEC_W-1:0] file_reg [NUM_REGS];
   logic [VEC_W-1:0] file_next [NUM_REGS];

   // Registered read answer and its next value.
   rd_rsp_t rsp_reg;
   rd_rsp_t rsp_next;

   // Write data after default-NaN substitution.
   logic [VEC_W-1:0] wr_fixed;

   // Raw operands picked by index, before width masking.
   logic [VEC_W-1:0] raw_a;
   logic [VEC_W-1:0] raw_b;

   // Width mask of the read request.
   logic [VEC_W-1:0] rd_mask;

   // Masked operands and their lane-wise logical result.
   logic [VEC_W-1:0] opnd_a;
   logic [VEC_W-1:0] opnd_b;
   logic [VEC_W-1:0] lgc_comb;

   // Per-lane classes of operand A.
   fp_class_t [NUM_LANES-1:0] cls_comb;

   // Implied integer bits; kept for the datapath, checked below.
   logic [NUM_LANES-1:0] hidden_comb;

   // Full 24-bit significands of operand A, implied bit on top.
   logic [NUM_LANES-1:0][PREC_BITS-1:0] signif_comb;

   // RULE2: no address path
   // The file has no port toward address generation; only operand data leaves it.
   // RULE7: separate storage file
   // No legacy stack state is aliased here, so no clearing operation is needed.
   // RULE16: mode independent
   // Nothing in the file depends on the execution mode of the processor.

   // Operand selection by register index; read-during-write returns old data.
   // Keeping the old value avoids a long forwarding path through the write mux.
   assign raw_a = file_reg[RD_REQ.idx_a];
   assign raw_b = file_reg[RD_REQ.idx_b];

   // Width mask of the read request; the byte enables are set with the read answer.
   always_comb begin
      unique case (RD_REQ.mode)
         // RULE8: all 128 bits
         MODE_FULL: begin
            rd_mask = {NUM_LANES{~LANE_RESET}};
         end
         // RULE4: 64-bit low block
         MODE_LOW64: begin
            rd_mask = {{(NUM_LANES/2){LANE_RESET}}, {(NUM_LANES/2){~LANE_RESET}}};
         end
         // RULE4: 64-bit high block
         MODE_HIGH64: begin
            rd_mask = {{(NUM_LANES/2){~LANE_RESET}}, {(NUM_LANES/2){LANE_RESET}}};
         end
         // RULE9: lane 0 only
         MODE_LANE32: begin
            rd_mask = {{(NUM_LANES-1){LANE_RESET}}, ~LANE_RESET};
         end
      endcase
   end

   // Masked operands as seen by the execution units.
   // Lanes outside the requested block read as zero, so a narrow store never drags stale bytes.
   assign opnd_a = raw_a & rd_mask;
   assign opnd_b = raw_b & rd_mask;

   // One lane slice per iteration: NaN substitution, logic op and class decode.
   // RULE3: lane l at bits 32*l up
   // RULE5: independent lanes
   for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
      // Lane slices of the operands.
      logic [LANE_W-1:0] la;
      logic [LANE_W-1:0] lb;

      assign la = opnd_a[l*LANE_W +: LANE_W];
      assign lb = opnd_b[l*LANE_W +: LANE_W];

      // RULE13: default quiet NaN
      // A masked invalid lane is replaced; an unmasked one is left to the trap path.
      assign wr_fixed[l*LANE_W +: LANE_W] = (WR_REQ.invalid[l] && INVALID_MASKED) ?
         DEFAULT_QNAN : WR_REQ.data[l*LANE_W +: LANE_W];

      // Bitwise lane operation; each lane sees only its own slices.
      // The result is built in a lane-local variable so that each slice of
      // the shared vector has exactly one driver.
      logic [LANE_W-1:0] lr;

      always_comb begin
         unique case (RD_REQ.op)
            OP_AND: begin
               lr = la & lb;
            end
            OP_ANDN: begin
               lr = ~la & lb;
            end
            OP_OR: begin
               lr = la | lb;
            end
            OP_XOR: begin
               lr = la ^ lb;
            end
         endcase
      end

      assign lgc_comb[l*LANE_W +: LANE_W] = lr;

      // RULE10: field decode per lane
      fp_lane_classify u_cls (
         .lane(la),
         .cls(cls_comb[l]),
         .hidden_bit(hidden_comb[l])
      );

      // RULE14: 24-bit significand per lane
      // The stored fraction gains the implied bit; only the checks read it so far.
      assign signif_comb[l] = {hidden_comb[l], la[FRAC_W-1:0]};
   end

   // Next state of the storage: only the addressed register changes.
   always_comb begin
      for (int r = 0; r < NUM_REGS; r++) begin
         file_next[r] = file_reg[r];
      end
      if (WR_REQ.en) begin
         unique case (WR_REQ.mode)
            // RULE8: full-width write
            MODE_FULL: begin
               file_next[WR_REQ.idx] = wr_fixed;
            end
            // RULE4: low 64-bit block, upper half kept
            MODE_LOW64: begin
               file_next[WR_REQ.idx][HALF_W-1:0] = wr_fixed[HALF_W-1:0];
            end
            // RULE4: high 64-bit block, lower half kept
            MODE_HIGH64: begin
               file_next[WR_REQ.idx][VEC_W-1:HALF_W] = wr_fixed[VEC_W-1:HALF_W];
            end
            // RULE9: scalar write, upper lanes pass
            MODE_LANE32: begin
               file_next[WR_REQ.idx][LANE_W-1:0] = wr_fixed[LANE_W-1:0];
            end
         endcase
      end
   end

   // Next value of the read answer.
   always_comb begin
      rsp_next.a = opnd_a;
      rsp_next.b = opnd_b;
      rsp_next.lgc = lgc_comb;
      rsp_next.cls_a = cls_comb;
      // RULE6: byte n at address base plus n
      // RULE15: scalar store four bytes
      unique case (RD_REQ.mode)
         MODE_FULL: begin
            rsp_next.store_be = BE_FULL;
         end
         MODE_LOW64: begin
            rsp_next.store_be = BE_LOW64;
         end
         MODE_HIGH64: begin
            rsp_next.store_be = BE_HIGH64;
         end
         MODE_LANE32: begin
            rsp_next.store_be = BE_LANE32;
         end
      endcase
   end

   // Storage and answer registers; reset clears every register to zero.
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         for (int r = 0; r < NUM_REGS; r++) begin
            file_reg[r] <= {NUM_LANES{LANE_RESET}};
         end
         rsp_reg <= '0;
      end else begin
         for (int r = 0; r < NUM_REGS; r++) begin
            file_reg[r] <= file_next[r];
         end
         rsp_reg <= rsp_next;
      end
   end

   // The answer leaves straight from its flip-flops.
   assign RD_RSP = rsp_reg;

   // Checks on the file; all in the single clock domain.
   // Every check is cut off while reset is low, so reset-time values never fire one.
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);

   // RULE8: full write lands whole
   AST_WR_FULL: assert property ( // RULE8
      WR_REQ.en && WR_REQ.mode == MODE_FULL && !(INVALID_MASKED && |WR_REQ.invalid)
      |=> file_reg[$past(WR_REQ.idx)] == $past(WR_REQ.data))
      else $error("Full write did not land in the addressed register.");

   // RULE9: scalar write keeps upper lanes
   AST_WR_LANE32: assert property ( // RULE9
      WR_REQ.en && WR_REQ.mode == MODE_LANE32
      |=> file_reg[$past(WR_REQ.idx)][VEC_W-1:LANE_W]
         == $past(file_reg[WR_REQ.idx][VEC_W-1:LANE_W]))
      else $error("Scalar write disturbed the upper lanes.");

   // RULE4: high block keeps low half
   AST_WR_HIGH64: assert property ( // RULE4
      WR_REQ.en && WR_REQ.mode == MODE_HIGH64
      && !(INVALID_MASKED && |WR_REQ.invalid[NUM_LANES-1:NUM_LANES/2])
      |=> file_reg[$past(WR_REQ.idx)] ==
         {$past(WR_REQ.data[VEC_W-1:HALF_W]), $past(file_reg[WR_REQ.idx][HALF_W-1:0])})
      else $error("High block write placed data wrongly.");

   // RULE13: masked invalid lane gets the default NaN
   AST_DEFAULT_NAN: assert property ( // RULE13
      WR_REQ.en && WR_REQ.mode != MODE_HIGH64 && WR_REQ.invalid[0] && INVALID_MASKED
      |=> file_reg[$past(WR_REQ.idx)][LANE_W-1:0] == DEFAULT_QNAN)
      else $error("Masked invalid lane was not replaced by the default NaN.");

   // RULE1: write then read returns the data two cycles on
   AST_WR_RD: assert property ( // RULE1
      WR_REQ.en && WR_REQ.mode == MODE_FULL && !(INVALID_MASKED && |WR_REQ.invalid)
      ##1 (RD_REQ.idx_a == $past(WR_REQ.idx) && RD_REQ.mode == MODE_FULL)
      |=> RD_RSP.a == $past(WR_REQ.data, 2))
      else $error("Read after write returned stale data.");

   // RULE9: scalar read shows lane 0 only and four byte enables
   AST_RD_LANE32: assert property ( // RULE9
      RD_REQ.mode == MODE_LANE32
      |=> RD_RSP.a[VEC_W-1:LANE_W] == '0 && RD_RSP.store_be == BE_LANE32)
      else $error("Scalar read leaked upper lanes or wrong byte enables.");

   // RULE5: each logic lane comes from the same lanes of A and B
   AST_LOGIC_XOR: assert property ( // RULE5
      RD_REQ.op == OP_XOR |=> RD_RSP.lgc == (RD_RSP.a ^ RD_RSP.b))
      else $error("Lane-wise exclusive or result mismatched its operands.");

   // RULE12: quiet NaN in lane 0 is classed as quiet
   AST_CLASS_QNAN: assert property ( // RULE12
      RD_RSP.a[EXP_MSB:EXP_LSB] == EXP_ALL_ONES && RD_RSP.a[QUIET_POS]
      |-> RD_RSP.cls_a[0] == CLS_QNAN)
      else $error("Quiet NaN was not classified as quiet.");

   // RULE11: implied bit clear exactly for zero and denormal
   AST_HIDDEN: assert property ( // RULE11
      hidden_comb[0] == !(cls_comb[0] == CLS_ZERO || cls_comb[0] == CLS_DENORM))
      else $error("Implied integer bit disagrees with the lane class.");

   // RULE4: low block keeps high half
   AST_WR_LOW64: assert property ( // RULE4
      WR_REQ.en && WR_REQ.mode == MODE_LOW64
      && !(INVALID_MASKED && |WR_REQ.invalid[NUM_LANES/2-1:0])
      |=> file_reg[$past(WR_REQ.idx)] ==
         {$past(file_reg[WR_REQ.idx][VEC_W-1:HALF_W]), $past(WR_REQ.data[HALF_W-1:0])})
      else $error("Low block write placed data wrongly.");

   // RULE8: full read passes both registers whole
   // The past value of the file is the one read, as no write is forwarded.
   AST_RD_FULL: assert property ( // RULE8
      RD_REQ.mode == MODE_FULL
      |=> RD_RSP.a == $past(file_reg[RD_REQ.idx_a])
         && RD_RSP.b == $past(file_reg[RD_REQ.idx_b])
         && RD_RSP.store_be == BE_FULL)
      else $error("Full read did not return both registers whole.");

   // RULE4: high block read shows the upper half only
   AST_RD_HIGH64: assert property ( // RULE4
      RD_REQ.mode == MODE_HIGH64
      |=> RD_RSP.a[HALF_W-1:0] == '0
         && RD_RSP.a[VEC_W-1:HALF_W] == $past(file_reg[RD_REQ.idx_a][VEC_W-1:HALF_W]))
      else $error("High block read placed data wrongly.");

   // RULE6: low block enables bytes 0 to 7 only
   AST_RD_LOW64: assert property ( // RULE6
      RD_REQ.mode == MODE_LOW64
      |=> RD_RSP.a[VEC_W-1:HALF_W] == '0 && RD_RSP.store_be == BE_LOW64)
      else $error("Low block read leaked upper bytes or wrong byte enables.");

   // RULE3: scalar read takes lane 0 from the low 32 bits
   AST_LANE_ORDER: assert property ( // RULE3
      RD_REQ.mode == MODE_LANE32
      |=> RD_RSP.a[LANE_W-1:0] == $past(file_reg[RD_REQ.idx_a][LANE_W-1:0]))
      else $error("Scalar read did not take the lowest lane.");

   // RULE12: all-ones exponent with zero fraction is infinity
   AST_CLASS_INF: assert property ( // RULE12
      RD_RSP.a[EXP_MSB:EXP_LSB] == EXP_ALL_ONES && RD_RSP.a[FRAC_W-1:0] == FRAC_ZERO
      |-> RD_RSP.cls_a[0] == CLS_INF)
      else $error("Infinity was not classified as infinity.");

   // RULE11: zero exponent with a nonzero fraction is a denormal
   AST_CLASS_DENORM: assert property ( // RULE11
      RD_RSP.a[EXP_MSB:EXP_LSB] == EXP_ALL_ZERO && RD_RSP.a[FRAC_W-1:0] != FRAC_ZERO
      |-> RD_RSP.cls_a[0] == CLS_DENORM)
      else $error("Denormal was not classified as a denormal.");

   // RULE14: normal lane carries a set implied bit above its fraction
   AST_SIGNIF: assert property ( // RULE14
      cls_comb[0] == CLS_NORMAL
      |-> signif_comb[0] == {1'b1, opnd_a[FRAC_W-1:0]})
      else $error("Normal lane lost its implied integer bit.");

   // Main scenarios worth seeing in simulation.
   COV_SCALAR_WR: cover property (WR_REQ.en && WR_REQ.mode == MODE_LANE32);
   COV_NAN_SUB: cover property (WR_REQ.en && |WR_REQ.invalid && INVALID_MASKED);
   COV_HIGH_RD: cover property (RD_REQ.mode == MODE_HIGH64 ##1 RD_RSP.store_be == BE_HIGH64);
   COV_SNAN: cover property (RD_RSP.cls_a[0] == CLS_SNAN);
   COV_WR_RD: cover property (WR_REQ.en && WR_REQ.mode == MODE_FULL ##1 RD_REQ.mode == MODE_FULL);

endmodule // vector_regfile

// [hdl/vreg_pkg.sv]
// Purpose: Shared constants, types and carriers of the packed vector register file.
// Assumes: Lanes hold single-precision values with a biased exponent.
// Notes: Every width, field position, encoding and byte-enable pattern lives here.
package vreg_pkg;

   // File geometry: eight registers of four 32-bit lanes.
   localparam int NUM_REGS = 8;
   localparam int IDX_W = 3;
   localparam int VEC_W = 128;
   localparam int LANE_W = 32;
   localparam int NUM_LANES = 4;
   localparam int HALF_W = 64;
   localparam int BYTES_PER_VEC = 16;

   // Single-precision field layout inside one lane.
   localparam int SIGN_POS = 31;
   localparam int EXP_MSB = 30;
   localparam int EXP_LSB = 23;
   localparam int EXP_W = 8;
   localparam int FRAC_W = 23;
   localparam int QUIET_POS = 22;
   localparam int EXP_BIAS = 127;
   localparam int PREC_BITS = 24;

   // Exponent patterns used by the classifier.
   localparam logic [EXP_W-1:0] EXP_ALL_ONES = 8'hFF;
   localparam logic [EXP_W-1:0] EXP_ALL_ZERO = 8'h00;
   localparam logic [FRAC_W-1:0] FRAC_ZERO = 23'h00_0000;

   // Default quiet NaN: sign set, exponent all ones, only the top fraction bit set.
   localparam logic [LANE_W-1:0] DEFAULT_QNAN = 32'hFFC0_0000;

   // Reset value of one lane.
   localparam logic [LANE_W-1:0] LANE_RESET = 32'h0000_0000;

   // Byte enables of a little-endian store, byte 0 at the lowest address.
   localparam logic [BYTES_PER_VEC-1:0] BE_FULL = 16'hFFFF;
   localparam logic [BYTES_PER_VEC-1:0] BE_LOW64 = 16'h00FF;
   localparam logic [BYTES_PER_VEC-1:0] BE_HIGH64 = 16'hFF00;
   localparam logic [BYTES_PER_VEC-1:0] BE_LANE32 = 16'h000F;

   // Access width and placement of one transfer.
   typedef enum logic [1:0] {
      MODE_FULL = 2'b00,
      MODE_LOW64 = 2'b01,
      MODE_HIGH64 = 2'b10,
      MODE_LANE32 = 2'b11
   } access_mode_t;

   // Bitwise lane operation of the read port.
   typedef enum logic [1:0] {
      OP_AND = 2'b00,
      OP_ANDN = 2'b01,
      OP_OR = 2'b10,
      OP_XOR = 2'b11
   } logic_op_t;

   // Encoding class of one lane.
   typedef enum logic [2:0] {
      CLS_ZERO = 3'b000,
      CLS_DENORM = 3'b001,
      CLS_NORMAL = 3'b010,
      CLS_INF = 3'b011,
      CLS_SNAN = 3'b100,
      CLS_QNAN = 3'b101
   } fp_class_t;

   // Write request from the execution units.
   typedef struct packed {
      logic en;
      logic [IDX_W-1:0] idx;
      access_mode_t mode;
      logic [VEC_W-1:0] data;
      logic [NUM_LANES-1:0] invalid;
   } wr_req_t;

   // Read request: two operand indices, width and lane operation.
   typedef struct packed {
      logic [IDX_W-1:0] idx_a;
      logic [IDX_W-1:0] idx_b;
      access_mode_t mode;
      logic_op_t op;
   } rd_req_t;

   // Registered read answer.
   typedef struct packed {
      logic [VEC_W-1:0] a;
      logic [VEC_W-1:0] b;
      logic [VEC_W-1:0] lgc;
      logic [BYTES_PER_VEC-1:0] store_be;
      fp_class_t [NUM_LANES-1:0] cls_a;
   } rd_rsp_t;

endpackage

// [hdl/fp_lane_classify.sv]
// Purpose: Classify one single-precision lane and recover its implied integer bit.
// Assumes: Purely combinational; the caller registers the class but not the implied bit.
// Notes: Stateless, so it can be replicated once per lane.
`timescale 1ns/100ps
module fp_lane_classify (
   input wire logic [vreg_pkg::LANE_W-1:0] lane,
   output vreg_pkg::fp_class_t cls,
   output logic hidden_bit
);
   import vreg_pkg::*;

   // Exponent and fraction views of the lane.
   logic [EXP_W-1:0] exp_field;
   logic [FRAC_W-1:0] frac_field;

   assign exp_field = lane[EXP_MSB:EXP_LSB];
   assign frac_field = lane[FRAC_W-1:0];

   // The implied bit is one except for zeros and denormals.
   // RULE11: implied bit decode
   assign hidden_bit = (exp_field != EXP_ALL_ZERO);

   // Class decode; the quiet bit splits the two NaN kinds.
   always_comb begin
      if (exp_field == EXP_ALL_ONES) begin
         // RULE12: infinity and NaN kinds
         if (frac_field == FRAC_ZERO) begin
            cls = CLS_INF;
         end else if (lane[QUIET_POS]) begin
            cls = CLS_QNAN;
         end else begin
            cls = CLS_SNAN;
         end
      end else if (exp_field == EXP_ALL_ZERO) begin
         cls = (frac_field == FRAC_ZERO) ? CLS_ZERO : CLS_DENORM;
      end else begin
         cls = CLS_NORMAL;
      end
   end

endmodule // fp_lane_classify

// [tb/exec_side_model.sv]
// Purpose: Stand-in for the decode and execution units facing the register file.
// Assumes: Requests change a fixed small delay after the rising clock edge.
// Notes: It only drives requests; the bench keeps the expected register contents.
`timescale 1ns/100ps
module exec_side_model (
   input wire logic clk,
   output vreg_pkg::wr_req_t wr,
   output vreg_pkg::rd_req_t rd,
   output logic inv_masked
);
   import vreg_pkg::*;

   // Idle requests from time zero, so no input of the file floats.
   initial begin
      wr = '0;
      rd = '0;
      inv_masked = 1'b0;
   end

   // One cycle of requests, launched just after the edge and held for the whole cycle.
   // A request stays up until the next issue, so callers issue an idle cycle before resting.
   task automatic issue(input wr_req_t w, input rd_req_t r, input logic m);
      @(posedge clk);
      #2;
      wr = w;
      rd = r;
      inv_masked = m;
   endtask
endmodule // exec_side_model

// [tb/vector_regfile_tb_top.sv]
// Purpose: Self-checking bench of the packed vector register file.
// Assumes: Reads answer exactly one cycle after the request; writes land at that edge.
// Notes: A shadow copy of the eight registers predicts every read answer.
`timescale 1ns/100ps
module vector_regfile_tb_top;
   import vreg_pkg::*;

   // One predicted answer and the cycle in which it must show.
   typedef struct {rd_rsp_t exp; int due;} note_t;
   logic sys_clk;
   logic rst_b;
   wr_req_t wr;
   rd_req_t rd;
   logic inv_m;
   rd_rsp_t rsp;
   logic [VEC_W-1:0] sh [NUM_REGS];
   note_t notes[$];
   int cyc = 0;
   int n_errors = 0;
   int checks_done = 0;
   logic [31:0] seed;

   exec_side_model u_model (.clk(sys_clk), .wr(wr), .rd(rd), .inv_masked(inv_m));
   vector_regfile u_dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .WR_REQ(wr),
      .INVALID_MASKED(inv_m), .RD_REQ(rd), .RD_RSP(rsp));

   // Free-running 50 MHz clock and a cycle count for answer timing.
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) cyc <= cyc + 1;

   // Compare one value and count it.
   task automatic check(input string what, input logic [$bits(rd_rsp_t)-1:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Print the counts and the verdict, then stop.
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Xorshift source, so every run sees the same stream.
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [VEC_W-1:0] span(input access_mode_t m);
      case (m)
         MODE_FULL: return '1;
         MODE_LOW64: return {64'h0, {64{1'b1}}};
         MODE_HIGH64: return {{64{1'b1}}, 64'h0};
         default: return {96'h0, 32'hFFFF_FFFF};
      endcase
   endfunction

   function automatic fp_class_t cls(input logic [31:0] v);
      if (v[30:23] == 8'h00) return (v[22:0] == 23'h0) ? CLS_ZERO : CLS_DENORM;
      if (v[30:23] != 8'hFF) return CLS_NORMAL;
      if (v[22:0] == 23'h0) return CLS_INF;
      return v[22] ? CLS_QNAN : CLS_SNAN;
   endfunction

   // Random lane biased toward zero and all-ones exponents, so every class turns up.
   function automatic logic [31:0] lane_rnd();
      logic [31:0] v;
      v = xs();
      if (v[1:0] == 2'b00) v[30:23] = 8'h00;
      if (v[1:0] == 2'b01) v[30:23] = 8'hFF;
      if (v[3:2] == 2'b00) v[22:0] = 23'h0;
      return v;
   endfunction

   // Issue one cycle, note the answer from the old shadow, then apply the write.
   // The prediction is taken before the write, since a same-cycle read sees old data.
   task automatic step(input wr_req_t w, input rd_req_t r, input logic m);
      note_t n;
      logic [VEC_W-1:0] k;
      logic [VEC_W-1:0] d;
      u_model.issue(w, r, m);
      k = span(r.mode);
      n.exp.a = sh[r.idx_a] & k;
      n.exp.b = sh[r.idx_b] & k;
      case (r.op)
         OP_AND: n.exp.lgc = n.exp.a & n.exp.b;
         OP_ANDN: n.exp.lgc = ~n.exp.a & n.exp.b;
         OP_OR: n.exp.lgc = n.exp.a | n.exp.b;
         default: n.exp.lgc = n.exp.a ^ n.exp.b;
      endcase
      for (int i = 0; i < BYTES_PER_VEC; i++) n.exp.store_be[i] = k[8*i];
      for (int l = 0; l < NUM_LANES; l++) n.exp.cls_a[l] = cls(n.exp.a[32*l +: 32]);
      n.due = cyc + 1;
      notes.push_back(n);
      k = span(w.mode);
      d = w.data;
      for (int l = 0; l < NUM_LANES; l++) if (m && w.invalid[l]) d[32*l +: 32] = 32'hFFC0_0000;
      if (w.en) sh[w.idx] = (sh[w.idx] & ~k) | (d & k);
   endtask

   // Random write and read in the same cycle, all modes and operations.
   task automatic rnd_step();
      wr_req_t w;
      rd_req_t r;
      logic [31:0] x;
      x = xs();
      w = '{x[0], x[3:1], access_mode_t'(x[5:4]),
         {lane_rnd(), lane_rnd(), lane_rnd(), lane_rnd()}, x[9:6]};
      r = '{x[12:10], x[15:13], access_mode_t'(x[17:16]), logic_op_t'(x[19:18])};
      step(w, r, x[20]);
   endtask

   // Read back every register in full width against the shadow.
   task automatic read_all();
      for (int i = 0; i < NUM_REGS; i++) step('0, '{3'(i), 3'(7 - i), MODE_FULL, OP_OR}, 1'b0);
   endtask

   // Reset in mid-run: an idle cycle first, since a held write would land again on release.
   task automatic do_reset();
      step('0, '0, 1'b0);
      repeat (2) @(posedge sys_clk);
      #2 rst_b = 1'b0;
      sh = '{default: '0};
      repeat (5) @(posedge sys_clk);
      #1 check("answer in reset", rsp, '0); // Held low
      #1 rst_b = 1'b1;
   endtask

   // Each due answer is taken off the queue at the falling edge, where it has settled.
   always @(negedge sys_clk) begin
      if (notes.size() > 0 && notes[0].due == cyc) begin
         check("read answer", rsp, notes[0].exp); // Lane view
         void'(notes.pop_front());
      end
   end

   // Watchdog: the tests need about 450 cycles; this allows over ten times that.
   initial begin
      #100_000;
      n_errors++;
      give_verdict();
   end

   initial begin
      seed = 32'h0001_28F6;
      rst_b = 1'b0;
      sh = '{default: '0};
      repeat (5) @(posedge sys_clk);
      #2 rst_b = 1'b1;
      read_all();
      // Class table in reg 5, read in the same cycle, then a masked scalar write.
      step('{1'b1, 3'h5, MODE_FULL, {32'h7F80_0000, 32'h7F80_0001, 32'h0000_0001,
         32'h8000_0000}, 4'h0}, '{3'h5, 3'h5, MODE_FULL, OP_XOR}, 1'b0);
      step('{1'b1, 3'h5, MODE_LANE32, '1, 4'hF}, '{3'h5, 3'h0, MODE_FULL, OP_ANDN}, 1'b1);
      step('{1'b1, 3'h6, MODE_HIGH64, '1, 4'hF}, '{3'h5, 3'h5, MODE_LOW64, OP_AND}, 1'b0);
      step('0, '{3'h6, 3'h5, MODE_HIGH64, OP_OR}, 1'b0);
      repeat (400) rnd_step();
      do_reset();
      read_all();
      step('0, '0, 1'b0);
      repeat (3) @(posedge sys_clk);
      check("answers left unseen", notes.size(), 0); // Every answer shown
      give_verdict();
   end
endmodule // vector_regfile_tb_top
